// ==== chdiv_pkg.sv ====
/*
 * Constants, field layouts and types for the channel divider block.
 * Assumes register offsets are printed byte addresses on the serial
 * control port and that all logic runs on one system clock.
 */
package chdiv_pkg;

    // Register offsets.
    localparam logic [9:0] CHDIV_ADDR_CH1_ROUTE = 10'h195;
    localparam logic [9:0] CHDIV_ADDR_DIV2_CNT = 10'h196;
    localparam logic [9:0] CHDIV_ADDR_DIV2_CTRL = 10'h197;
    localparam logic [9:0] CHDIV_ADDR_CH2_ROUTE = 10'h198;
    localparam logic [9:0] CHDIV_ADDR_DIV3_CNT = 10'h199;

    // Reset values.
    localparam logic [7:0] CHDIV_RST_ROUTE = 8'h00;
    localparam logic [7:0] CHDIV_RST_DIV2_CNT = 8'h11;
    localparam logic [7:0] CHDIV_RST_DIV2_CTRL = 8'h00;
    localparam logic [7:0] CHDIV_RST_DIV3_CNT = 8'h00;
    localparam logic [7:0] CHDIV_RST_DIV3_CTRL = 8'h00;
    localparam logic [7:0] CHDIV_RDATA_NONE = 8'h00;

    // Field positions of the channel route and power register.
    localparam int CHDIV_ROUTE_PD_BIT = 2;
    localparam int CHDIV_ROUTE_DIRECT_BIT = 1;
    localparam int CHDIV_ROUTE_DCC_OFF_BIT = 0;
    localparam logic [7:0] CHDIV_ROUTE_MASK = 8'h07;

    // Source select codes for the direct route.
    localparam logic [1:0] CHDIV_SRC_OSC = 2'h2;
    localparam logic [1:0] CHDIV_SRC_CLKIN = 2'h0;

    // Indices into the synchronised pin vector.
    localparam int CHDIV_PIN_DIV2_IN = 0;
    localparam int CHDIV_PIN_DIV3_IN = 1;
    localparam int CHDIV_PIN_DIV1_OUT = 2;
    localparam int CHDIV_PIN_OSC = 3;
    localparam int CHDIV_PIN_CLKIN = 4;
    localparam int CHDIV_PIN_SYNC_N = 5;
    localparam int CHDIV_NPINS = 6;
    localparam int CHDIV_NDIV = 2;
    // Idle level of the pin vector; only the active-low sync pin idles high.
    localparam logic [CHDIV_NPINS-1:0] CHDIV_PIN_IDLE = 6'h20;

    // Divider control register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic bypass;
        logic ignore_sync;
        logic force_out;
        logic start_high;
        logic [3:0] phase;
    } chdiv_ctrl_t;

    // Cycle count register layout.
    typedef struct packed {
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
    } chdiv_cnt_t;

    // Register write and read request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } chdiv_req_t;

    // Divider sequencer states.
    typedef enum logic [3:0] {
        CHDIV_ST_HOLD = 4'b0001,
        CHDIV_ST_PHASE = 4'b0010,
        CHDIV_ST_LOW = 4'b0100,
        CHDIV_ST_HIGH = 4'b1000
    } chdiv_st_t;

endpackage

// ==== chdiv_top.sv ====
/*
 * Channel 1 control, divider 2 with channel 2, and divider 3 counting.
 * Assumes divider inputs, oscillator, clock input and sync arrive as
 * asynchronous pins slower than half of clk_sys, and that the source
 * select field lives elsewhere and comes in as a plain input.
 */
`timescale 1ns/100ps

module chdiv_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire chdiv_pkg::chdiv_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic div2_in_clk,
    input wire logic div3_in_clk,
    input wire logic div1_out,
    input wire logic osc_clk,
    input wire logic clk_in_pin,
    input wire logic sync_n,
    input wire logic [1:0] source_select,
    output logic div2_out,
    output logic div3_out,
    output logic output_pair_three,
    output logic output_pair_four,
    output logic output_pair_five,
    output logic output_pair_six,
    output logic output_pair_seven,
    output logic output_pair_eight,
    output logic [1:0] duty_cycle_correction_en
);
    import chdiv_pkg::*;

    logic [7:0] ch1_route_r;
    logic [7:0] ch2_route_r;
    chdiv_cnt_t div2_cnt_r;
    chdiv_ctrl_t div2_ctrl_r;
    chdiv_cnt_t div3_cnt_r;
    logic [CHDIV_NPINS-1:0] pin_s1_r;
    logic [CHDIV_NPINS-1:0] pin_s2_r;
    logic [CHDIV_NPINS-1:0] pin_s3_r;
    logic [CHDIV_NPINS-1:0] pin_rise;
    logic sync_hold;
    chdiv_cnt_t cnt_arr [CHDIV_NDIV];
    chdiv_ctrl_t ctrl_arr [CHDIV_NDIV];
    logic in_lvl [CHDIV_NDIV];
    logic in_rise [CHDIV_NDIV];
    logic dout_r [CHDIV_NDIV];
    logic [2:0] ch1_r;
    logic [2:0] ch2_r;
    logic [4:0] reg_hit;

    // Picks the level a channel drives from its route register.
    function automatic logic chdiv_route(input logic [7:0] route,
                                         input logic [1:0] sel,
                                         input logic div_lvl,
                                         input logic osc_lvl,
                                         input logic clk_lvl);
        logic lvl;
        lvl = div_lvl;
        if (route[CHDIV_ROUTE_DIRECT_BIT] && sel == CHDIV_SRC_OSC) begin
            lvl = osc_lvl;
        end else if (route[CHDIV_ROUTE_DIRECT_BIT] &&
                     sel == CHDIV_SRC_CLKIN) begin
            lvl = clk_lvl;
        end
        if (route[CHDIV_ROUTE_PD_BIT]) begin
            lvl = 1'b0;
        end
        return lvl;
    endfunction

    // One-hot decode of the mapped offsets, shared by writes and reads.
    function automatic logic [4:0] chdiv_decode(input logic [9:0] addr);
        logic [4:0] sel;
        sel = 5'h00;
        sel[0] = (addr == CHDIV_ADDR_CH1_ROUTE);
        sel[1] = (addr == CHDIV_ADDR_DIV2_CNT);
        sel[2] = (addr == CHDIV_ADDR_DIV2_CTRL);
        sel[3] = (addr == CHDIV_ADDR_CH2_ROUTE);
        sel[4] = (addr == CHDIV_ADDR_DIV3_CNT);
        return sel;
    endfunction

    // Decoded offset of the current request; unmapped offsets give zero.
    assign reg_hit = chdiv_decode(reg_req.addr);

    // Channel 1 route and power; bits above the defined three read zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ch1_route_r <= CHDIV_RST_ROUTE;
        end else if (reg_req.wr && reg_hit[0]) begin
            ch1_route_r <= reg_req.wdata & CHDIV_ROUTE_MASK;
        end
    end

    // Divider 2 low and high cycle counts.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div2_cnt_r <= CHDIV_RST_DIV2_CNT;
        end else if (reg_req.wr && reg_hit[1]) begin
            div2_cnt_r <= reg_req.wdata;
        end
    end

    // Divider 2 control; a new value acts from the next cycle on.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div2_ctrl_r <= CHDIV_RST_DIV2_CTRL;
        end else if (reg_req.wr && reg_hit[2]) begin
            div2_ctrl_r <= reg_req.wdata;
        end
    end

    // Channel 2 route and power; bits above the defined three read zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ch2_route_r <= CHDIV_RST_ROUTE;
        end else if (reg_req.wr && reg_hit[3]) begin
            ch2_route_r <= reg_req.wdata & CHDIV_ROUTE_MASK;
        end
    end

    // Divider 3 low and high cycle counts.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div3_cnt_r <= CHDIV_RST_DIV3_CNT;
        end else if (reg_req.wr && reg_hit[4]) begin
            div3_cnt_r <= reg_req.wdata;
        end
    end

    // A read strobe is answered by a one-cycle valid pulse.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
        end
    end

    // Read data follows the decoded offset; a same-cycle write is not seen.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= CHDIV_RDATA_NONE;
        end else begin
            unique case (reg_hit)
                5'h01: reg_rdata <= ch1_route_r;
                5'h02: reg_rdata <= div2_cnt_r;
                5'h04: reg_rdata <= div2_ctrl_r;
                5'h08: reg_rdata <= ch2_route_r;
                5'h10: reg_rdata <= div3_cnt_r;
                default: reg_rdata <= CHDIV_RDATA_NONE;
            endcase
        end
    end

    // Two-stage synchronisers; reset to idle so no false sync hold follows.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_s1_r <= CHDIV_PIN_IDLE;
            pin_s2_r <= CHDIV_PIN_IDLE;
        end else begin
            pin_s1_r <= {sync_n, clk_in_pin, osc_clk, div1_out,
                         div3_in_clk, div2_in_clk};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Third stage, kept only to find rising edges of the synced levels.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_s3_r <= CHDIV_PIN_IDLE;
        end else begin
            pin_s3_r <= pin_s2_r;
        end
    end

    // Rising edges and the chip-level sync request.
    assign pin_rise = pin_s2_r & ~pin_s3_r;
    assign sync_hold = ~pin_s2_r[CHDIV_PIN_SYNC_N];

    // Divider 3 control is held at its default here.
    assign cnt_arr[0] = div2_cnt_r;
    assign cnt_arr[1] = div3_cnt_r;
    assign ctrl_arr[0] = div2_ctrl_r;
    assign ctrl_arr[1] = CHDIV_RST_DIV3_CTRL;
    assign in_lvl[0] = pin_s2_r[CHDIV_PIN_DIV2_IN];
    assign in_lvl[1] = pin_s2_r[CHDIV_PIN_DIV3_IN];
    assign in_rise[0] = pin_rise[CHDIV_PIN_DIV2_IN];
    assign in_rise[1] = pin_rise[CHDIV_PIN_DIV3_IN];

    // One sequencer per divider, counting input rising edges.
    for (genvar g = 0; g < CHDIV_NDIV; g++) begin : g_div
        chdiv_st_t st_r;
        logic [3:0] cnt_r;
        logic held;
        logic forced;

        // Sync stops the divider unless it is told to ignore sync.
        assign held = sync_hold && !ctrl_arr[g].ignore_sync;
        // Static output needs ignore-sync as well as force.
        assign forced = ctrl_arr[g].force_out &&
                        ctrl_arr[g].ignore_sync;

        // Low and high phases each last their count plus one edges.
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                st_r <= CHDIV_ST_HOLD;
                cnt_r <= 4'h0;
            end else if (held || forced || ctrl_arr[g].bypass) begin
                st_r <= CHDIV_ST_HOLD;
                cnt_r <= 4'h0;
            end else if (in_rise[g]) begin
                unique case (st_r)
                    CHDIV_ST_HOLD: begin
                        if (ctrl_arr[g].phase != 4'h0) begin
                            st_r <= CHDIV_ST_PHASE;
                            cnt_r <= ctrl_arr[g].phase - 4'h1;
                        end else if (ctrl_arr[g].start_high) begin
                            st_r <= CHDIV_ST_HIGH;
                            cnt_r <= cnt_arr[g].high_cnt;
                        end else begin
                            st_r <= CHDIV_ST_LOW;
                            cnt_r <= cnt_arr[g].low_cnt;
                        end
                    end
                    CHDIV_ST_PHASE: begin
                        if (cnt_r != 4'h0) begin
                            cnt_r <= cnt_r - 4'h1;
                        end else if (ctrl_arr[g].start_high) begin
                            st_r <= CHDIV_ST_HIGH;
                            cnt_r <= cnt_arr[g].high_cnt;
                        end else begin
                            st_r <= CHDIV_ST_LOW;
                            cnt_r <= cnt_arr[g].low_cnt;
                        end
                    end
                    CHDIV_ST_LOW: begin
                        if (cnt_r != 4'h0) begin
                            cnt_r <= cnt_r - 4'h1;
                        end else begin
                            st_r <= CHDIV_ST_HIGH;
                            cnt_r <= cnt_arr[g].high_cnt;
                        end
                    end
                    CHDIV_ST_HIGH: begin
                        if (cnt_r != 4'h0) begin
                            cnt_r <= cnt_r - 4'h1;
                        end else begin
                            st_r <= CHDIV_ST_LOW;
                            cnt_r <= cnt_arr[g].low_cnt;
                        end
                    end
                    default: begin
                        st_r <= CHDIV_ST_HOLD;
                        cnt_r <= 4'h0;
                    end
                endcase
            end
        end

        // Output level; bypass outranks force, sync hold drives low.
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                dout_r[g] <= 1'b0;
            end else if (ctrl_arr[g].bypass) begin
                dout_r[g] <= in_lvl[g];
            end else if (forced) begin
                dout_r[g] <= ctrl_arr[g].start_high;
            end else if (held) begin
                dout_r[g] <= 1'b0;
            end else begin
                dout_r[g] <= (st_r == CHDIV_ST_HIGH);
            end
        end
    end

    assign div2_out = dout_r[0];
    assign div3_out = dout_r[1];

    // Channel 1 trio follows divider 1 or a direct source, one flop each.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ch1_r <= 3'h0;
        end else begin
            ch1_r <= {3{chdiv_route(ch1_route_r, source_select,
                                    pin_s2_r[CHDIV_PIN_DIV1_OUT],
                                    pin_s2_r[CHDIV_PIN_OSC],
                                    pin_s2_r[CHDIV_PIN_CLKIN])}};
        end
    end

    // Channel 2 trio follows divider 2 or a direct source, one flop each.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ch2_r <= 3'h0;
        end else begin
            ch2_r <= {3{chdiv_route(ch2_route_r, source_select,
                                    dout_r[0],
                                    pin_s2_r[CHDIV_PIN_OSC],
                                    pin_s2_r[CHDIV_PIN_CLKIN])}};
        end
    end

    assign output_pair_three = ch1_r[0];
    assign output_pair_four = ch1_r[1];
    assign output_pair_five = ch1_r[2];
    assign output_pair_six = ch2_r[0];
    assign output_pair_seven = ch2_r[1];
    assign output_pair_eight = ch2_r[2];

    // Duty-cycle correction enables for the analog channel stage.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            duty_cycle_correction_en <= 2'h3;
        end else begin
            duty_cycle_correction_en <= {
                ~ch2_route_r[CHDIV_ROUTE_DCC_OFF_BIT],
                ~ch1_route_r[CHDIV_ROUTE_DCC_OFF_BIT]};
        end
    end

endmodule // chdiv_top

// ==== chdiv_top_sva.sv ====
/* Port checker for the channel divider block.
   Assumes it is bound to chdiv_top and sees only its ports. */
`timescale 1ns/100ps
module chdiv_top_sva
    import chdiv_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire chdiv_pkg::chdiv_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic div2_in_clk,
    input wire logic sync_n,
    input wire logic div2_out,
    input wire logic output_pair_three,
    input wire logic output_pair_four,
    input wire logic output_pair_five,
    input wire logic output_pair_six,
    input wire logic output_pair_seven,
    input wire logic output_pair_eight,
    input wire logic [1:0] duty_cycle_correction_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] shd_r [5];
    logic [7:0] exp_r;
    logic [2:0] idx;
    logic hit;
    chdiv_ctrl_t ctl;
    // Decode of the five mapped offsets into shadow slots.
    assign hit = reg_req.addr >= 10'h195 && reg_req.addr <= 10'h199;
    assign idx = reg_req.addr[2:0] - 3'h5;
    assign ctl = shd_r[2];
    // Shadow registers follow bus writes; channel slots keep three bits.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shd_r <= '{8'h00, 8'h11, 8'h00, 8'h00, 8'h00};
        end else if (reg_req.wr && hit) begin
            shd_r[idx] <= (idx == 3'h0 || idx == 3'h3) ?
                reg_req.wdata & 8'h07 : reg_req.wdata;
        end
    end
    // Expected read data, taken before a same-cycle write lands.
    always_ff @(posedge clk_sys) begin
        exp_r <= hit ? shd_r[idx] : 8'h00;
    end
    AST_RDATA: assert property (reg_req.rd |=> reg_rvalid &&
        reg_rdata == exp_r) else $error("read data differs from shadow");
    AST_TRIO1: assert property (output_pair_three == output_pair_four &&
        output_pair_four == output_pair_five) else $error("ch1 trio split");
    AST_TRIO2: assert property (output_pair_six == output_pair_seven &&
        output_pair_seven == output_pair_eight) else $error("ch2 trio split");
    AST_PD1: assert property (shd_r[0][2] [*2] |-> !output_pair_three)
        else $error("ch1 output active while powered down");
    AST_PD2: assert property (shd_r[3][2] [*2] |-> !output_pair_six)
        else $error("ch2 output active while powered down");
    AST_DCC: assert property ($stable(shd_r[0][0]) |->
        duty_cycle_correction_en[0] == !shd_r[0][0]) else $error("dcc mismatch");
    AST_FORCE: assert property (($stable(ctl) && ctl.ignore_sync &&
        ctl.force_out && !ctl.bypass) [*3] |-> div2_out == ctl.start_high)
        else $error("forced level not driven");
    AST_SYNC: assert property ((!sync_n && !ctl.ignore_sync &&
        !ctl.bypass) [*6] |-> !div2_out) else $error("output runs in sync hold");
    AST_BYPASS: assert property ((ctl.bypass && div2_in_clk) [*5] |->
        div2_out) else $error("bypass did not pass input");
    COV_WR: cover property (reg_req.wr);
    COV_BYP: cover property (ctl.bypass && div2_out);
    COV_CH2: cover property ($rose(output_pair_six));
endmodule // chdiv_top_sva

bind chdiv_top chdiv_top_sva u_sva (.clk_sys(clk_sys), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .div2_in_clk(div2_in_clk), .sync_n(sync_n), .div2_out(div2_out),
    .output_pair_three(output_pair_three), .output_pair_four(output_pair_four),
    .output_pair_five(output_pair_five), .output_pair_six(output_pair_six),
    .output_pair_seven(output_pair_seven),
    .output_pair_eight(output_pair_eight),
    .duty_cycle_correction_en(duty_cycle_correction_en));

// ==== chdiv_top_tb.sv ====
/* Self-checking bench for the channel divider block.
   Assumes a 250 MHz clk_sys and one input clock of twelve cycles. */
`timescale 1ns/100ps
module chdiv_top_tb;
    import chdiv_pkg::*;
    logic clk_sys, rst, in_clk, div1_out, osc_clk, clk_in_pin, sync_n;
    chdiv_pkg::chdiv_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid, div2_out, div3_out, op3, op4, op5, op6, op7, op8;
    logic [1:0] source_select, dcc_en;
    int miscompares, compares;
    chdiv_top u_dut (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .div2_in_clk(in_clk),
        .div3_in_clk(in_clk), .div1_out(div1_out), .osc_clk(osc_clk),
        .clk_in_pin(clk_in_pin), .sync_n(sync_n),
        .source_select(source_select), .div2_out(div2_out),
        .div3_out(div3_out), .output_pair_three(op3), .output_pair_four(op4),
        .output_pair_five(op5), .output_pair_six(op6), .output_pair_seven(op7),
        .output_pair_eight(op8), .duty_cycle_correction_en(dcc_en));
    // System clock, and a divider input clock toggling every six cycles.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        in_clk = 1'b0;
        forever begin
            repeat (6) @(posedge clk_sys);
            #1 in_clk = ~in_clk;
        end
    end
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h", $time,
                     got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        cyc(1);
        reg_req = '{1'b1, 1'b0, a, d};
        cyc(1);
        reg_req = '0;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        cyc(1);
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        cyc(1);
        reg_req = '0;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, e);
    endtask
    // Bounded wait for a level; sel 0 divider 2, 1 divider 3, 2 input clock.
    task automatic wait_lvl(input int sel, input logic lvl, output int c);
        c = 0;
        while ((sel == 0 ? div2_out : sel == 1 ? div3_out : in_clk)
               !== lvl) begin
            cyc(1);
            c++;
            if (c > 400) begin
                miscompares++;
                end_sim();
            end
        end
    endtask
    // Measures one high and one low time, in input cycles of twelve clocks.
    task automatic meas(input int sel, input int lo, input int hi);
        int h;
        int l;
        cyc(120);
        wait_lvl(sel, 1'b0, h);
        wait_lvl(sel, 1'b1, h);
        wait_lvl(sel, 1'b0, h);
        wait_lvl(sel, 1'b1, l);
        chk(8'(h), 8'(hi * 12));
        chk(8'(l), 8'(lo * 12));
        chk(8'(h + l), 8'((lo + hi) * 12));
    endtask
    task automatic t_reset;
        rd_chk(10'h195, 8'h00);
        rd_chk(10'h196, 8'h11);
        rd_chk(10'h197, 8'h00);
        rd_chk(10'h198, 8'h00);
        rd_chk(10'h199, 8'h00);
        rd_chk(10'h19A, 8'h00);
        chk({6'h00, dcc_en}, 8'h03);
        wr(10'h198, 8'hFF);
        rd_chk(10'h198, 8'h07);
        wr(10'h198, 8'h00);
    endtask
    task automatic t_divide;
        meas(0, 2, 2);
        meas(1, 1, 1);
        wr(10'h196, 8'h23);
        meas(0, 3, 4);
        wr(10'h196, 8'hF0);
        meas(0, 16, 1);
        wr(10'h196, 8'h11);
    endtask
    task automatic t_route;
        logic [4:0] tbl [5] = '{5'b10101, 5'b10010, 5'b00011, 5'b00100,
            5'b01110};
        wr(10'h197, 8'h60);
        wr(10'h198, 8'h02);
        for (int i = 0; i < 5; i++) begin
            source_select = tbl[i][4:3];
            osc_clk = tbl[i][2];
            clk_in_pin = tbl[i][1];
            cyc(8);
            chk({7'h00, op6}, {7'h00, tbl[i][0]});
        end
        wr(10'h198, 8'h00);
        wr(10'h197, 8'h70);
        cyc(8);
        chk({7'h00, op6}, 8'h01);
        wr(10'h198, 8'h04);
        cyc(8);
        chk({7'h00, op6}, 8'h00);
        div1_out = 1'b1;
        cyc(8);
        chk({7'h00, op3}, 8'h01);
        wr(10'h195, 8'h05);
        cyc(8);
        chk({7'h00, op3}, 8'h00);
        chk({6'h00, dcc_en}, 8'h02);
        wr(10'h195, 8'h00);
        wr(10'h198, 8'h00);
    endtask
    task automatic t_bypass;
        int c;
        wr(10'h197, 8'hF0);
        for (int v = 0; v < 2; v++) begin
            wait_lvl(2, 1'(v ^ 1), c);
            wait_lvl(2, 1'(v), c);
            cyc(5);
            chk({7'h00, div2_out}, 8'(v));
        end
    endtask
    task automatic t_sync;
        int c;
        logic [7:0] ctl [3] = '{8'h00, 8'h10, 8'h12};
        logic [7:0] ex [3] = '{8'h00, 8'h01, 8'h00};
        for (int i = 0; i < 3; i++) begin
            wr(10'h197, ctl[i]);
            sync_n = 1'b0;
            cyc(10);
            chk({7'h00, div2_out}, 8'h00);
            sync_n = 1'b1;
            cyc(6);
            wait_lvl(2, 1'b0, c);
            wait_lvl(2, 1'b1, c);
            cyc(5);
            chk({7'h00, div2_out}, ex[i]);
        end
        wr(10'h197, 8'h40);
        sync_n = 1'b0;
        meas(0, 2, 2);
        sync_n = 1'b1;
    endtask
    // Main sequence: reset for six cycles, then each scenario in turn.
    initial begin
        rst = 1'b1;
        reg_req = '0;
        div1_out = 1'b0;
        osc_clk = 1'b0;
        clk_in_pin = 1'b0;
        sync_n = 1'b1;
        source_select = 2'b01;
        miscompares = 0;
        compares = 0;
        repeat (6) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset();
        t_divide();
        t_route();
        t_bypass();
        t_sync();
        end_sim();
    end
endmodule // chdiv_top_tb
